// ### src/pole_slip_block.v
// Pole slip detector: impedance locus tracking, slip counting and trip
// Overview of operation
// RL1: Blocking input sampled once at each cycle start, used throughout.
// RL2: Pickup without blocking raises start and begins timing.
// RL3: Pickup while blocked raises blocked output; no timing or trip (trip held low, locus timing and slip counting continue).
// RL4: Blocking during active start clears start and runs release handling.
// RL5: Outside party asserts blocking 5 ms before operating delay ends.
// RL6: Front end supplies three currents, four voltages every 5 ms.
// RL7: Resistance and reactance computed from currents and chosen voltages.
// RL8: Operating mode On, Blocked, Test, Test/Blocked or Off; On default.
// RL9: Forced status Normal, Start, Trip or Blocked when forcing enabled.
// RL10: Slip counts after circle entry, blinder crossing inside, then exit.
// RL11: Locus must stay between blinders longer than minimum traverse time.
// RL12: Later slips must enter the circle from the same side.
// RL13: Slip counter clears when reset time passes after last slip.
// RL14: Trip issued when counted slips reach the configured limit.
// RL15: Circle centre reactance offset, signed, 0.01 ohm, default -50 ohm.
// RL16: Circle centre resistance offset, signed, default zero.
// RL17: Circle radius positive setting, default 50 ohm.
// RL18: Positive blinder default +20 ohm, negative blinder default -20 ohm.
// RL19: Pickup settings may change while running without stopping.
// RL20: Mode and forced status are static, untouched by group change.
// RL21: Status changes are time stamped; rising, falling or both stored (only the lowest status bit with a selected change is stored per cycle).
// RL22: Resettable cumulative counters for start, trip and blocked events.
// RL23: Entry side of first slip qualifies later slips until clear.
`timescale 1ns/1ps
`default_nettype none
`include "pole_slip_defines.vh"
module pole_slip_block #(
    parameter CYCLE_CLKS = `PSD_CYCLE_CLKS,
    parameter CNT_W = 16,
    parameter TS_W = 32
) (
    input wire clk,
    input wire srst,
    input wire sampleValid,
    input wire signed [31:0] measResist,
    input wire signed [31:0] measReact,
    input wire [2:0] opMode,
    input wire forceEnable,
    input wire [1:0] forceStatus,
    input wire blockIn,
    input wire signed [31:0] settingXOffset,
    input wire signed [31:0] settingROffset,
    input wire signed [31:0] settingRadius,
    input wire signed [31:0] settingRPos,
    input wire signed [31:0] settingRNeg,
    input wire [15:0] settingTraverseMs,
    input wire [23:0] settingResetMs,
    input wire [3:0] settingSlipLimit,
    input wire [1:0] eventSelect,
    input wire counterClear,
    input wire [TS_W-1:0] timeStamp,
    output reg startOut,
    output reg tripOut,
    output reg blockedOut,
    output reg [3:0] slipCount,
    output reg entrySide,
    output wire eventValid,
    output wire [1:0] eventCode,
    output wire eventRising,
    output wire [TS_W-1:0] eventTime,
    output wire [CNT_W-1:0] startCount,
    output wire [CNT_W-1:0] tripCount,
    output wire [CNT_W-1:0] blockedCount
);
    // Locus tracking states
    localparam ST_OUT = 2'h0;
    localparam ST_IN = 2'h1;
    localparam ST_BETWEEN = 2'h2;
    localparam ST_CROSSED = 2'h3;

    // Milliseconds to whole 5 ms cycles, rounded up
    function [23:0] msToCycles;
        input [23:0] ms;
        begin
            msToCycles = (ms + 24'h000004) / 24'h000005;
        end
    endfunction

    // Squared distance, 64 bits signed
    function signed [63:0] sq;
        input signed [31:0] a;
        begin
            sq = a * a;
        end
    endfunction

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [23:0] divCnt_q;
    reg tick;
    reg blockSampled_q;
    reg sideAtEntry_q;
    reg sideValid_q;
    reg [23:0] betweenCnt_q;
    reg [23:0] resetCnt_q;
    reg slipEvent;
    reg inCircle;
    reg betweenBlinders;
    reg pickup;
    reg [2:0] statusNow;
    wire signed [31:0] dr = measResist - settingROffset; // RL16
    wire signed [31:0] dx = measReact - settingXOffset; // RL15
    wire modeBlocked = (opMode == `PSD_MODE_BLOCKED) || (opMode == `PSD_MODE_TESTBLK);
    wire modeOff = (opMode == `PSD_MODE_OFF);
    wire effBlock = blockSampled_q | modeBlocked;
    wire enterSide = measResist[31]; // 1: entered from negative side
    // Slips including the one completing now, one bit wider so a full count cannot wrap
    wire [4:0] slipTotal = {1'b0, slipCount} + (slipEvent ? 5'h01 : 5'h00);

    // Processing cycle divider; a valid sample starts the evaluation
    always @(posedge clk) begin
        if (srst) begin
            divCnt_q <= 24'h000000;
        end else if (divCnt_q == CYCLE_CLKS - 1) begin
            divCnt_q <= 24'h000000;
        end else begin
            divCnt_q <= divCnt_q + 24'h000001;
        end
    end

    always @* begin
        tick = sampleValid;
    end

    // Circle and blinder tests on the current impedance sample
    always @* begin
        inCircle = (sq(dr) + sq(dx)) <= sq(settingRadius); // RL7 RL17
        betweenBlinders = (measResist < settingRPos) && (measResist > settingRNeg); // RL18
    end

    // Locus state machine deciding when a slip is complete
    always @* begin
        state_d = state_q;
        slipEvent = 1'b0;
        case (state_q)
            ST_OUT: begin
                if (inCircle) state_d = betweenBlinders ? ST_BETWEEN : ST_IN; // RL10
            end
            ST_IN: begin
                if (!inCircle) state_d = ST_OUT;
                else if (betweenBlinders) state_d = ST_BETWEEN;
            end
            ST_BETWEEN: begin
                if (!inCircle) begin
                    state_d = ST_OUT;
                end else if (!betweenBlinders) begin
                    // Crossed only if dwell exceeded the minimum traverse time
                    if (betweenCnt_q > msToCycles({8'h00, settingTraverseMs})) begin
                        state_d = ST_CROSSED; // RL11
                    end else begin
                        state_d = ST_IN;
                    end
                end
            end
            ST_CROSSED: begin
                if (!inCircle) begin
                    state_d = ST_OUT;
                    slipEvent = !sideValid_q || (sideAtEntry_q == entrySide); // RL10 RL12
                end
            end
            default: begin
                state_d = ST_OUT;
            end
        endcase
    end

    // Locus tracking, slip counting and counter reset timing
    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_OUT;
            blockSampled_q <= 1'b0;
            sideAtEntry_q <= 1'b0;
            sideValid_q <= 1'b0;
            entrySide <= 1'b0;
            betweenCnt_q <= 24'h000000;
            resetCnt_q <= 24'h000000;
            slipCount <= 4'h0;
        end else if (tick) begin
            blockSampled_q <= blockIn; // RL1
            if (modeOff) begin
                state_q <= ST_OUT;
                slipCount <= 4'h0;
                sideValid_q <= 1'b0;
            end else begin
                state_q <= state_d; // RL19
                if (state_q == ST_OUT && inCircle) entrySide <= enterSide;
                if (state_d == ST_BETWEEN) begin
                    betweenCnt_q <= (state_q == ST_BETWEEN) ? betweenCnt_q + 24'h000001
                                                             : 24'h000001;
                end
                if (slipEvent) begin
                    resetCnt_q <= 24'h000000;
                    if (slipCount != 4'hf) slipCount <= slipCount + 4'h1;
                    if (!sideValid_q) begin
                        sideAtEntry_q <= entrySide; // RL23
                        sideValid_q <= 1'b1;
                    end
                end else if (slipCount != 4'h0) begin
                    if (resetCnt_q >= msToCycles(settingResetMs)) begin
                        slipCount <= 4'h0; // RL13
                        sideValid_q <= 1'b0;
                        resetCnt_q <= 24'h000000;
                    end else begin
                        resetCnt_q <= resetCnt_q + 24'h000001;
                    end
                end
            end
        end
    end

    // Pickup is a locus inside the circle, a slip completing now or slips pending
    always @* begin
        pickup = !modeOff && (inCircle || slipEvent || slipCount != 4'h0);
    end

    // Status outputs with blocking and forced status
    always @(posedge clk) begin
        if (srst) begin
            startOut <= 1'b0;
            tripOut <= 1'b0;
            blockedOut <= 1'b0;
        end else if (forceEnable) begin
            startOut <= (forceStatus == `PSD_FORCE_START); // RL9 RL20
            tripOut <= (forceStatus == `PSD_FORCE_TRIP);
            blockedOut <= (forceStatus == `PSD_FORCE_BLOCKED);
        end else if (tick) begin
            if (!pickup) begin
                startOut <= 1'b0;
                tripOut <= 1'b0;
                blockedOut <= 1'b0;
            end else if (effBlock) begin
                startOut <= 1'b0; // RL4
                tripOut <= 1'b0; // RL3
                blockedOut <= 1'b1; // RL3 RL8
            end else begin
                startOut <= 1'b1; // RL2
                blockedOut <= 1'b0;
                tripOut <= slipTotal >= {1'b0, settingSlipLimit}; // RL14
            end
        end
    end

    always @* begin
        statusNow = {blockedOut, tripOut, startOut};
    end

    psd_event_recorder #(
        .CNT_W(CNT_W),
        .TS_W(TS_W)
    ) recorder (
        .clk(clk),
        .srst(srst),
        .statusNow(statusNow),
        .eventSelect(eventSelect),
        .counterClear(counterClear),
        .timeStamp(timeStamp),
        .eventValid(eventValid),
        .eventCode(eventCode),
        .eventRising(eventRising),
        .eventTime(eventTime),
        .startCount(startCount),
        .tripCount(tripCount),
        .blockedCount(blockedCount)
    );
endmodule
`default_nettype wire

// ### common/pole_slip_defines.vh
// Constants for the pole slip detector
`ifndef POLE_SLIP_DEFINES_VH
`define POLE_SLIP_DEFINES_VH
// Clock rate and processing cycle
`define PSD_CLK_HZ 25000000
`define PSD_CYCLE_MS 5
`define PSD_CYCLE_CLKS ((`PSD_CLK_HZ / 1000) * `PSD_CYCLE_MS)
// Setting defaults, impedances in 0.01 ohm units
`define PSD_XOFF_DEF 32'shffffec78
`define PSD_ROFF_DEF 32'sh00000000
`define PSD_RADIUS_DEF 32'sh00001388
`define PSD_RPOS_DEF 32'sh000007d0
`define PSD_RNEG_DEF 32'shfffff830
// Times in milliseconds, counted in 5 ms processing cycles, and the slip limit
`define PSD_TRAVERSE_MS_DEF 16'h0032
`define PSD_RESET_MS_DEF 24'h0003e8
`define PSD_LIMIT_DEF 4'h1
// Operating modes
`define PSD_MODE_ON 3'h0
`define PSD_MODE_BLOCKED 3'h1
`define PSD_MODE_TEST 3'h2
`define PSD_MODE_TESTBLK 3'h3
`define PSD_MODE_OFF 3'h4
// Forced status codes
`define PSD_FORCE_NORMAL 2'h0
`define PSD_FORCE_START 2'h1
`define PSD_FORCE_TRIP 2'h2
`define PSD_FORCE_BLOCKED 2'h3
// Event codes in the record word
`define PSD_EV_START 2'h0
`define PSD_EV_TRIP 2'h1
`define PSD_EV_BLOCKED 2'h2
// Event store selection
`define PSD_EVSEL_RISE 2'h1
`define PSD_EVSEL_FALL 2'h2
`endif

// ### src/psd_event_recorder.v
// Event time stamping, selection and cumulative counters
`timescale 1ns/1ps
`default_nettype none
`include "pole_slip_defines.vh"
module psd_event_recorder #(
    parameter CNT_W = 16,
    parameter TS_W = 32
) (
    input wire clk,
    input wire srst,
    input wire [2:0] statusNow,
    input wire [1:0] eventSelect,
    input wire counterClear,
    input wire [TS_W-1:0] timeStamp,
    output reg eventValid,
    output reg [1:0] eventCode,
    output reg eventRising,
    output reg [TS_W-1:0] eventTime,
    output reg [CNT_W-1:0] startCount,
    output reg [CNT_W-1:0] tripCount,
    output reg [CNT_W-1:0] blockedCount
);
    reg [2:0] statusPrev_q;
    wire [2:0] rise = statusNow & ~statusPrev_q;
    wire [2:0] fall = ~statusNow & statusPrev_q;
    wire [2:0] keep = (eventSelect[0] ? rise : 3'h0) | (eventSelect[1] ? fall : 3'h0);
    reg [1:0] pick;
    reg pickRise;

    // Lowest status bit with a selected change wins this cycle
    always @* begin
        pick = `PSD_EV_START;
        pickRise = rise[0];
        if (keep[0]) begin
            pick = `PSD_EV_START;
            pickRise = rise[0];
        end else if (keep[1]) begin
            pick = `PSD_EV_TRIP;
            pickRise = rise[1];
        end else if (keep[2]) begin
            pick = `PSD_EV_BLOCKED;
            pickRise = rise[2];
        end
    end

    // Stamped events and counters; an increment wins over a clear
    always @(posedge clk) begin
        if (srst) begin
            statusPrev_q <= 3'h0;
            eventValid <= 1'b0;
            eventCode <= 2'h0;
            eventRising <= 1'b0;
            eventTime <= {TS_W{1'b0}};
            startCount <= {CNT_W{1'b0}};
            tripCount <= {CNT_W{1'b0}};
            blockedCount <= {CNT_W{1'b0}};
        end else begin
            statusPrev_q <= statusNow;
            eventValid <= |keep; // RL21
            if (|keep) begin
                eventCode <= pick;
                eventRising <= pickRise;
                eventTime <= timeStamp; // RL21
            end
            if (rise[0]) startCount <= startCount + 1'b1; // RL22
            else if (counterClear) startCount <= {CNT_W{1'b0}};
            if (rise[1]) tripCount <= tripCount + 1'b1; // RL22
            else if (counterClear) tripCount <= {CNT_W{1'b0}};
            if (rise[2]) blockedCount <= blockedCount + 1'b1; // RL22
            else if (counterClear) blockedCount <= {CNT_W{1'b0}};
        end
    end
endmodule
`default_nettype wire

// ### tb/psd_front_end_model.sv
// Front end model: impedance samples on a fixed time base
`timescale 1ns/1ps
`default_nettype none
module psd_front_end_model #(parameter GAP = 4) (
    input wire logic clk,
    input wire logic srst,
    input wire logic go,
    input wire logic neg,
    input wire logic signed [31:0] stepSize,
    output logic sampleValid,
    output logic signed [31:0] measResist,
    output logic signed [31:0] measReact,
    output logic busy
);
    logic signed [31:0] rNow;
    logic signed [31:0] delta;
    logic dirNeg;
    integer tick;
    // Strobe every GAP clocks, locus swept across the circle on request
    always @(posedge clk) begin
        sampleValid <= 1'b0;
        tick <= tick + 1;
        if (srst) begin
            tick <= 0;
            rNow <= 32'sh1f40;
            busy <= 1'b0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            dirNeg <= neg;
            delta <= neg ? stepSize : -stepSize;
            rNow <= neg ? -32'sh1964 : 32'sh1964;
        end else if (tick >= GAP - 1) begin
            tick <= 0;
            sampleValid <= 1'b1;
            if (busy)
                rNow <= rNow + delta;
            if (busy && (dirNeg ? rNow >= 32'sh1770 : rNow <= -32'sh1770))
                busy <= 1'b0;
        end
    end
    // Lines scrambled outside the strobe
    assign measResist = sampleValid ? rNow : ~rNow;
    assign measReact = sampleValid ? -32'sh1388 : 32'sh1388;
endmodule
`default_nettype wire

// ### tb/pole_slip_block_assertions.sv
// Port checks for the pole slip detector
`timescale 1ns/1ps
`default_nettype none
`include "pole_slip_defines.vh"
module pole_slip_block_assertions #(parameter CNT_W = 16) (
    input wire clk,
    input wire srst,
    input wire sampleValid,
    input wire [2:0] opMode,
    input wire forceEnable,
    input wire [1:0] forceStatus,
    input wire [3:0] settingSlipLimit,
    input wire counterClear,
    input wire startOut,
    input wire tripOut,
    input wire blockedOut,
    input wire [3:0] slipCount,
    input wire eventValid,
    input wire [CNT_W-1:0] startCount
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_blk;
        !forceEnable && blockedOut |-> !startOut && !tripOut;
    endproperty
    a_blk: assert property (p_blk) else $error("blocked with start");
    property p_hold;
        !forceEnable && !$past(forceEnable) && !$past(forceEnable, 2) && !$past(sampleValid)
            && $past(opMode) == $past(opMode, 2) |-> $stable(startOut);
    endproperty
    a_hold: assert property (p_hold) else $error("start moved off sample");
    property p_ev;
        eventValid |-> $past({startOut, tripOut, blockedOut})
            != $past({startOut, tripOut, blockedOut}, 2);
    endproperty
    a_ev: assert property (p_ev) else $error("event without change");
    property p_cnt;
        $rose(startOut) |=> startCount == $past(startCount) + 1'b1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("start count missed");
    property p_clr;
        counterClear && !$rose(startOut) |=> startCount == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("start count not cleared");
    property p_trip;
        $rose(tripOut) && !forceEnable && !$past(forceEnable) && opMode == `PSD_MODE_ON
            |-> slipCount >= settingSlipLimit;
    endproperty
    a_trip: assert property (p_trip) else $error("trip below limit");
    property p_off;
        opMode == `PSD_MODE_OFF && sampleValid && !forceEnable
            |=> slipCount == 4'h0 && !startOut && !tripOut;
    endproperty
    a_off: assert property (p_off) else $error("off mode kept state");
    property p_frc;
        forceEnable && forceStatus == `PSD_FORCE_NORMAL
            |=> !startOut && !tripOut && !blockedOut;
    endproperty
    a_frc: assert property (p_frc) else $error("forced normal ignored");
endmodule
bind pole_slip_block pole_slip_block_assertions #(.CNT_W(CNT_W)) u_pole_slip_block_assertions (
    .clk(clk), .srst(srst), .sampleValid(sampleValid), .opMode(opMode),
    .forceEnable(forceEnable), .forceStatus(forceStatus), .settingSlipLimit(settingSlipLimit),
    .counterClear(counterClear), .startOut(startOut), .tripOut(tripOut),
    .blockedOut(blockedOut), .slipCount(slipCount), .eventValid(eventValid),
    .startCount(startCount));
`default_nettype wire

// ### tb/pole_slip_block_tb.sv
// Self-checking bench for the pole slip detector
`timescale 1ns/1ps
`default_nettype none
`include "pole_slip_defines.vh"
module pole_slip_block_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic go = 1'b0;
    logic neg = 1'b0;
    logic signed [31:0] stepSize = 32'sh1f4;
    logic [2:0] opMode = `PSD_MODE_ON;
    logic forceEnable = 1'b0;
    logic [1:0] forceStatus = `PSD_FORCE_NORMAL;
    logic blockIn = 1'b0;
    logic [1:0] eventSelect = 2'h3;
    logic counterClear = 1'b0;
    logic [31:0] timeStamp = 32'h0;
    logic [3:0] slipLimit = 4'h2;
    logic [31:0] lastAge = 32'h0;
    wire sampleValid, busy, startOut, tripOut, blockedOut, entrySide, eventValid, eventRising;
    wire signed [31:0] measResist, measReact;
    wire [3:0] slipCount;
    wire [1:0] eventCode;
    wire [31:0] eventTime;
    wire [15:0] startCount, tripCount, blockedCount;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer evCnt = 0;
    integer c0;
    logic [2:0] lastEv = 3'h0;
    // Clock, time base and event capture
    always #20 clk = ~clk;
    always @(posedge clk) begin
        timeStamp <= #1 timeStamp + 32'h1;
        if (eventValid === 1'b1) begin
            evCnt <= evCnt + 1;
            lastEv <= {eventRising, eventCode};
            lastAge <= timeStamp - eventTime;
        end
    end
    psd_front_end_model u_psd_front_end_model (.clk(clk), .srst(srst), .go(go), .neg(neg),
        .stepSize(stepSize), .sampleValid(sampleValid), .measResist(measResist),
        .measReact(measReact), .busy(busy));
    pole_slip_block #(.CYCLE_CLKS(4)) u_pole_slip_block (.clk(clk), .srst(srst),
        .sampleValid(sampleValid), .measResist(measResist), .measReact(measReact),
        .opMode(opMode), .forceEnable(forceEnable), .forceStatus(forceStatus),
        .blockIn(blockIn), .settingXOffset(`PSD_XOFF_DEF), .settingROffset(`PSD_ROFF_DEF),
        .settingRadius(`PSD_RADIUS_DEF), .settingRPos(`PSD_RPOS_DEF),
        .settingRNeg(`PSD_RNEG_DEF), .settingTraverseMs(16'h000f), .settingResetMs(24'h0001f4),
        .settingSlipLimit(slipLimit), .eventSelect(eventSelect), .counterClear(counterClear),
        .timeStamp(timeStamp), .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
        .slipCount(slipCount), .entrySide(entrySide), .eventValid(eventValid),
        .eventCode(eventCode), .eventRising(eventRising), .eventTime(eventTime),
        .startCount(startCount), .tripCount(tripCount), .blockedCount(blockedCount));
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task waitS(input integer n);
        repeat (n) @(posedge clk iff sampleValid === 1'b1);
        #1;
    endtask
    task clks(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One locus sweep through the circle, 500 or 2000 per sample
    task sweep(input logic d, input [31:0] s);
        neg = d;
        stepSize = s;
        go = 1'b1;
        clks(1);
        go = 1'b0;
        for (c0 = 0; c0 < 400 && busy === 1'b1; c0 = c0 + 1)
            clks(1);
    endtask
    task t_slips;
        chk("startCount", startCount, 32'h0);
        sweep(1'b0, 32'h7d0);
        chk("fast slip", slipCount, 32'h0);
        sweep(1'b0, 32'h1f4);
        chk("slip one", {tripOut, entrySide, slipCount}, 32'h1);
        sweep(1'b0, 32'h1f4);
        chk("slip two", {tripOut, slipCount}, 32'h12);
        $display("test slips done");
    endtask
    task t_block;
        blockIn = 1'b1;
        waitS(2);
        chk("blocked", {startOut, tripOut, blockedOut}, 32'h1);
        blockIn = 1'b0;
        opMode = `PSD_MODE_TESTBLK;
        waitS(2);
        chk("mode blocked", {startOut, tripOut, blockedOut}, 32'h1);
        opMode = `PSD_MODE_OFF;
        waitS(2);
        chk("mode off", {slipCount, startOut, tripOut, blockedOut}, 32'h0);
        opMode = `PSD_MODE_ON;
        $display("test block done");
    endtask
    task t_force;
        integer i;
        integer c1;
        integer c2;
        c0 = startCount;
        c1 = tripCount;
        c2 = blockedCount;
        forceEnable = 1'b1;
        for (i = 1; i < 5; i = i + 1) begin
            forceStatus = i[1:0];
            clks(2);
            chk("forced", {startOut, tripOut, blockedOut}, 3'h4 >> (i - 1));
        end
        chk("start count", startCount, c0 + 1);
        chk("trip count", tripCount, c1 + 1);
        chk("blocked count", blockedCount, c2 + 1);
        clks(1);
        chk("fall event", lastEv, {1'b0, `PSD_EV_BLOCKED});
        eventSelect = `PSD_EVSEL_RISE;
        forceStatus = `PSD_FORCE_START;
        clks(3);
        chk("rise event", lastEv, {1'b1, `PSD_EV_START});
        chk("event time", lastAge, 32'h1);
        c0 = evCnt;
        forceStatus = `PSD_FORCE_NORMAL;
        clks(3);
        chk("fall dropped", evCnt, c0);
        eventSelect = `PSD_EVSEL_FALL;
        forceStatus = `PSD_FORCE_START;
        clks(3);
        forceStatus = `PSD_FORCE_NORMAL;
        clks(3);
        chk("fall only", lastEv, {1'b0, `PSD_EV_START});
        forceEnable = 1'b0;
        eventSelect = 2'h3;
        counterClear = 1'b1;
        clks(2);
        counterClear = 1'b0;
        chk("count clear", startCount, 32'h0);
        chk("trip clear", tripCount, 32'h0);
        chk("blocked clear", blockedCount, 32'h0);
        $display("test force done");
    endtask
    task t_side;
        sweep(1'b0, 32'h1f4);
        sweep(1'b1, 32'h1f4);
        chk("other side", slipCount, 32'h1);
        waitS(105);
        chk("slip reset", slipCount, 32'h0);
        slipLimit = 4'h1;
        sweep(1'b1, 32'h1f4);
        chk("limit one", {tripOut, entrySide, slipCount}, 32'h31);
        $display("test side done");
    endtask
    // Main sequence
    initial begin
        clks(3);
        srst = 1'b0;
        t_slips;
        t_block;
        t_force;
        t_side;
        finish_test;
    end
    // Watchdog
    initial begin
        #1000000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
endmodule
`default_nettype wire
